// ### hw/fpcp_params.svh
`ifndef FPCP_PARAMS_SVH
`define FPCP_PARAMS_SVH
// ****************************************
// Clock and conversion
// ****************************************
`define FPCP_CLK_MHZ 50
`define FPCP_CYC_UP(ns) (((ns) * `FPCP_CLK_MHZ + 999) / 1000)
// ****************************************
// Scheme codes and ratios
// ****************************************
`define FPCP_SCH_X8 2'h0
`define FPCP_SCH_X16 2'h1
`define FPCP_SCH_X32 2'h2
`define FPCP_MASK_X8 32'h000000FF
`define FPCP_MASK_X16 32'h0000FFFF
`define FPCP_MASK_X32 32'hFFFFFFFF
`define FPCP_RATIO_1 4'h1
`define FPCP_RATIO_2 4'h2
`define FPCP_RATIO_4 4'h4
`define FPCP_RATIO_8 4'h8
// ****************************************
// Timing
// ****************************************
`define FPCP_POR_NS 100000
`define FPCP_TCFG_MIN_NS 2000
`define FPCP_TST2CK_MIN_NS 2000
`define FPCP_TSTAT_MIN_NS 268000
`define FPCP_TSTAT_MAX_NS 1506000
`define FPCP_TCF2ST0_MAX_NS 600
`define FPCP_TUM_MIN_NS 175000
`define FPCP_TUM_MAX_NS 437000
`define FPCP_UINIT_PERIODS 8576
`define FPCP_UINIT_GAP_PERIODS 4
`define FPCP_END_FALLS 2
`endif

// ### hw/fpcp_pkg.sv
`default_nettype none
`include "fpcp_params.svh"
package fpcp_pkg;
   typedef enum logic [4:0] {
      D_POR = 5'h01,
      D_RST = 5'h02,
      D_LOAD = 5'h04,
      D_INIT = 5'h08,
      D_USER = 5'h10
   } fpcp_dev_st_t;

   typedef enum logic [8:0] {
      H_IDLE = 9'h001,
      H_REQ = 9'h002,
      H_WST = 9'h004,
      H_GAP = 9'h008,
      H_LOADW = 9'h010,
      H_SEND = 9'h020,
      H_WDONE = 9'h040,
      H_FALL = 9'h080,
      H_DONE = 9'h100
   } fpcp_host_st_t;

   function automatic logic [3:0] fpcp_ratio(input logic [1:0] sch, input logic dec,
                                             input logic sec);
      if (sch == `FPCP_SCH_X16) begin
         fpcp_ratio = dec ? `FPCP_RATIO_4 : (sec ? `FPCP_RATIO_2 : `FPCP_RATIO_1);
      end else if (sch == `FPCP_SCH_X32) begin
         fpcp_ratio = dec ? `FPCP_RATIO_8 : (sec ? `FPCP_RATIO_4 : `FPCP_RATIO_1);
      end else begin
         fpcp_ratio = dec ? `FPCP_RATIO_2 : `FPCP_RATIO_1;
      end
   endfunction : fpcp_ratio

   function automatic logic [31:0] fpcp_mask(input logic [1:0] sch);
      if (sch == `FPCP_SCH_X16) begin
         fpcp_mask = `FPCP_MASK_X16;
      end else if (sch == `FPCP_SCH_X32) begin
         fpcp_mask = `FPCP_MASK_X32;
      end else begin
         fpcp_mask = `FPCP_MASK_X8;
      end
   endfunction : fpcp_mask
endpackage : fpcp_pkg
`default_nettype wire

// ### hw/fpcp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fpcp_link_if;
   logic config_request_n;
   logic config_clock;
   logic [31:0] data;
   logic user_init_clock;
   logic status_o;
   logic status_oe;
   logic done_o;
   logic done_oe;
   logic init_o;
   logic init_oe;
   logic status_n;
   logic load_complete;
   logic init_complete;
   // Open-drain lines with pull-ups.
   assign status_n = status_oe ? status_o : 1'b1;
   assign load_complete = done_oe ? done_o : 1'b1;
   assign init_complete = init_oe ? init_o : 1'b1;
   modport dev(input config_request_n, config_clock, data, user_init_clock, status_n,
               load_complete, output status_o, status_oe, done_o, done_oe, init_o, init_oe);
   modport host(output config_request_n, config_clock, data, user_init_clock,
                input status_n, load_complete, init_complete);
endinterface : fpcp_link_if
`default_nettype wire

// ### hw/fpcp_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpcp_params.svh"
// Notes on behaviour
// - 8-bit ratio: 1, or 2 with decompression.
// - 16-bit ratio: 1, security 2, decompression 4.
// - 32-bit ratio: 1, security 4, decompression 8.
// - Host holds each word ratio clock cycles.
// - Host clocks ratio-1 more after last latch.
// - Status, load complete and init complete high in user mode; request restarts.
// - Status held low for power-on delay.
// - Load complete low until image accepted.
// - Load complete rises after the last word received.
// - Two falling edges after load complete start init.
// - Init complete low until init ends, if enabled.
// - Clock ignored after the two closing falls; host drives it.
// - Width selects data lines 7, 15 or 31.
// - Request low drives both lines low quickly.
// - Host holds request low at least 2 us.
// - Status low 268 to 1506 us.
// - Host waits before first clock rising edge.
// - Host keeps clock rate and duty limits.
// - Internal init: user mode 175-437 us later.
// - User init clock: 4 periods gap, 8576 periods.
module fpcp_device #(
   parameter int unsigned IMAGE_WORDS = 16,
   parameter int unsigned POR_CYC = `FPCP_CYC_UP(`FPCP_POR_NS),
   parameter int unsigned STAT_MIN_CYC = `FPCP_CYC_UP(`FPCP_TSTAT_MIN_NS),
   parameter int unsigned UM_CYC = `FPCP_CYC_UP(`FPCP_TUM_MIN_NS),
   parameter int unsigned UINIT_PERIODS = `FPCP_UINIT_PERIODS
) (
   // Link to the loading host.
   fpcp_link_if.dev LINK,
   // System clock and reset.
   input wire logic CLK,
   input wire logic RST_B,
   // Load options.
   input wire logic [1:0] SCHEME_SEL,
   input wire logic DECOMP_EN,
   input wire logic SECURE_EN,
   input wire logic UINIT_CLK_EN,
   input wire logic INIT_PIN_EN,
   // Status.
   output logic USER_MODE,
   output logic [31:0] LAST_WORD
);
   // ****************************************
   // Synchronisers into the system clock
   // ****************************************
   logic req_m_r, req_s_r, done_m_r, done_s_r, go_m_r, go_s_r;
   logic uck_m_r, uck_s_r, uck_d_r;
   logic done_lk_r, go_lk_r;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         req_m_r <= 1'b1;
         req_s_r <= 1'b1;
         done_m_r <= 1'b0;
         done_s_r <= 1'b0;
         go_m_r <= 1'b0;
         go_s_r <= 1'b0;
         uck_m_r <= 1'b0;
         uck_s_r <= 1'b0;
         uck_d_r <= 1'b0;
      end else begin
         req_m_r <= LINK.config_request_n;
         req_s_r <= req_m_r;
         done_m_r <= done_lk_r;
         done_s_r <= done_m_r;
         go_m_r <= go_lk_r;
         go_s_r <= go_m_r;
         uck_m_r <= LINK.user_init_clock;
         uck_s_r <= uck_m_r;
         uck_d_r <= uck_s_r;
      end
   end

   // ****************************************
   // Sequence state
   // ****************************************
   fpcp_pkg::fpcp_dev_st_t st_r, st_nxt;
   logic [16:0] cnt_r;
   logic [13:0] ucnt_r;
   logic uopt_r, iopt_r, load_en_r, init_en_r, user_r;
   logic [2:0] rm1_r;
   logic [31:0] mask_r;
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         fpcp_pkg::D_POR: if (cnt_r >= 17'(POR_CYC)) begin
            st_nxt = req_s_r ? fpcp_pkg::D_LOAD : fpcp_pkg::D_RST;
         end
         fpcp_pkg::D_RST: if (cnt_r >= 17'(STAT_MIN_CYC) && req_s_r) begin
            st_nxt = fpcp_pkg::D_LOAD;
         end
         fpcp_pkg::D_LOAD: if (done_s_r) begin
            st_nxt = fpcp_pkg::D_INIT;
         end
         fpcp_pkg::D_INIT: if (go_s_r && (uopt_r ? ucnt_r >= 14'(UINIT_PERIODS) :
                                          cnt_r >= 17'(UM_CYC))) begin
            st_nxt = fpcp_pkg::D_USER;
         end
         fpcp_pkg::D_USER: begin
         end
      endcase
      if (!req_s_r && st_r != fpcp_pkg::D_POR) begin
         st_nxt = fpcp_pkg::D_RST;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= fpcp_pkg::D_POR;
         cnt_r <= '0;
         load_en_r <= 1'b0;
         init_en_r <= 1'b0;
         user_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= (st_nxt != st_r) ? '0 : (cnt_r + 17'(cnt_r != '1));
         load_en_r <= st_nxt == fpcp_pkg::D_LOAD;
         init_en_r <= st_nxt == fpcp_pkg::D_LOAD || st_nxt == fpcp_pkg::D_INIT;
         user_r <= st_nxt == fpcp_pkg::D_USER;
      end
   end

   // Options are caught as the load opens and stay fixed while it runs.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         uopt_r <= 1'b0;
         iopt_r <= 1'b0;
         rm1_r <= '0;
         mask_r <= '0;
      end else if (st_nxt == fpcp_pkg::D_LOAD && st_r != fpcp_pkg::D_LOAD) begin
         uopt_r <= UINIT_CLK_EN;
         iopt_r <= INIT_PIN_EN;
         rm1_r <= 3'(fpcp_pkg::fpcp_ratio(SCHEME_SEL, DECOMP_EN, SECURE_EN) - 4'h1);
         mask_r <= fpcp_pkg::fpcp_mask(SCHEME_SEL);
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ucnt_r <= '0;
      end else if (st_r != fpcp_pkg::D_INIT || !go_s_r) begin
         ucnt_r <= '0;
      end else if (uck_s_r && !uck_d_r && ucnt_r != '1) begin
         ucnt_r <= ucnt_r + 14'h0001;
      end
   end

   // ****************************************
   // Link outputs
   // ****************************************
   assign LINK.status_o = 1'b0;
   assign LINK.done_o = 1'b0;
   assign LINK.init_o = 1'b0;
   assign LINK.status_oe = st_r == fpcp_pkg::D_POR || st_r == fpcp_pkg::D_RST;
   assign LINK.done_oe = st_r != fpcp_pkg::D_INIT && st_r != fpcp_pkg::D_USER;
   assign LINK.init_oe = iopt_r && st_r == fpcp_pkg::D_INIT;
   assign USER_MODE = user_r;

   // ****************************************
   // Link clock domain
   // ****************************************
   // The load enable acts as the reset here. The host gives no clock edge for
   // microseconds after status rises, so its release never meets an edge.
   logic [2:0] sub_r;
   logic [15:0] wcnt_r, wcnt_nxt;
   assign wcnt_nxt = wcnt_r + 16'(sub_r == 3'h0);
   always_ff @(posedge LINK.config_clock or negedge load_en_r) begin
      if (!load_en_r) begin
         sub_r <= '0;
         wcnt_r <= '0;
         done_lk_r <= 1'b0;
      // Edges after the load are ignored.
      end else if (!done_lk_r) begin
         wcnt_r <= wcnt_nxt;
         sub_r <= (sub_r == rm1_r) ? 3'h0 : sub_r + 3'h1;
         if (sub_r == rm1_r && wcnt_nxt == 16'(IMAGE_WORDS)) begin
            done_lk_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge LINK.config_clock or negedge RST_B) begin
      if (!RST_B) begin
         LAST_WORD <= '0;
      // Only the selected lines are kept.
      end else if (load_en_r && !done_lk_r && sub_r == 3'h0) begin
         LAST_WORD <= LINK.data & mask_r;
      end
   end

   // Falling edges are counted only once load complete shows high, so the
   // trailing fall of the last word cannot stand in for one of the two.
   logic [1:0] fall_r;
   always_ff @(negedge LINK.config_clock or negedge init_en_r) begin
      if (!init_en_r) begin
         fall_r <= '0;
         go_lk_r <= 1'b0;
      end else if (!load_en_r && !go_lk_r) begin
         fall_r <= fall_r + 2'h1;
         go_lk_r <= fall_r == 2'(`FPCP_END_FALLS - 1);
      end
   end
endmodule : fpcp_device
`default_nettype wire

// ### hw/fpcp_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpcp_params.svh"
module fpcp_host #(
   parameter int unsigned DIV_HALF = 1,
   parameter int unsigned UDIV_HALF = 2,
   parameter int unsigned CFG_CYC = `FPCP_CYC_UP(`FPCP_TCFG_MIN_NS),
   parameter int unsigned GAP_CYC = `FPCP_CYC_UP(`FPCP_TST2CK_MIN_NS)
) (
   // Link to the device.
   fpcp_link_if.host LINK,
   // System clock and reset.
   input wire logic CLK,
   input wire logic RST_B,
   // Load options.
   input wire logic [1:0] SCHEME_SEL,
   input wire logic DECOMP_EN,
   input wire logic SECURE_EN,
   input wire logic UINIT_CLK_EN,
   // Image source.
   input wire logic START,
   input wire logic [31:0] WORD,
   input wire logic WORD_LAST,
   input wire logic WORD_VALID,
   output logic WORD_READY,
   // Status.
   output logic BUSY,
   output logic LOADED
);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic st_m_r, st_s_r, dn_m_r, dn_s_r;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_m_r <= 1'b0;
         st_s_r <= 1'b0;
         dn_m_r <= 1'b0;
         dn_s_r <= 1'b0;
      end else begin
         st_m_r <= LINK.status_n;
         st_s_r <= st_m_r;
         dn_m_r <= LINK.load_complete;
         dn_s_r <= dn_m_r;
      end
   end

   // ****************************************
   // Clock dividers
   // ****************************************
   fpcp_pkg::fpcp_host_st_t st_r;
   logic [7:0] div_r, udiv_r;
   logic ck_r, uck_r, uon_r, run, tick, rise, fall;
   logic [3:0] ratio;
   assign ratio = fpcp_pkg::fpcp_ratio(SCHEME_SEL, DECOMP_EN, SECURE_EN);
   assign run = st_r == fpcp_pkg::H_SEND || st_r == fpcp_pkg::H_FALL;
   assign tick = div_r == 8'(DIV_HALF - 1);
   assign rise = run && tick && !ck_r;
   assign fall = run && tick && ck_r;
   // Rate set by the divider, even duty.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         div_r <= '0;
         ck_r <= 1'b0;
      end else if (!run) begin
         div_r <= '0;
         ck_r <= 1'b0;
      end else begin
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         ck_r <= ck_r ^ tick;
      end
   end
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         udiv_r <= '0;
         uck_r <= 1'b0;
      end else if (!uon_r) begin
         udiv_r <= '0;
         uck_r <= 1'b0;
      end else if (udiv_r == 8'(UDIV_HALF - 1)) begin
         udiv_r <= '0;
         uck_r <= !uck_r;
      end else begin
         udiv_r <= udiv_r + 8'h01;
      end
   end
   // Clock rests at a driven low.
   assign LINK.config_clock = ck_r;
   assign LINK.user_init_clock = uck_r;

   // ****************************************
   // Load sequence
   // ****************************************
   logic [16:0] cnt_r;
   logic [3:0] sub_r;
   logic last_r, req_r;
   logic [31:0] data_r;
   assign WORD_READY = st_r == fpcp_pkg::H_LOADW;
   assign LINK.data = data_r;
   assign LINK.config_request_n = req_r;
   assign BUSY = st_r != fpcp_pkg::H_IDLE && st_r != fpcp_pkg::H_DONE;
   assign LOADED = dn_s_r;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= fpcp_pkg::H_IDLE;
         cnt_r <= '0;
         sub_r <= '0;
         last_r <= 1'b0;
         req_r <= 1'b1;
         data_r <= '0;
         uon_r <= 1'b0;
      end else begin
         cnt_r <= (cnt_r != '1) ? cnt_r + 17'h00001 : cnt_r;
         unique case (st_r)
            fpcp_pkg::H_IDLE, fpcp_pkg::H_DONE: begin
               if (st_r == fpcp_pkg::H_DONE && UINIT_CLK_EN &&
                   cnt_r >= 17'(`FPCP_UINIT_GAP_PERIODS * 2 * DIV_HALF)) begin
                  uon_r <= 1'b1;
               end
               if (START) begin
                  st_r <= fpcp_pkg::H_REQ;
                  req_r <= 1'b0;
                  uon_r <= 1'b0;
                  cnt_r <= '0;
               end
            end
            fpcp_pkg::H_REQ: if (cnt_r >= 17'(CFG_CYC)) begin
               req_r <= 1'b1;
               st_r <= fpcp_pkg::H_WST;
            end
            fpcp_pkg::H_WST: if (st_s_r) begin
               st_r <= fpcp_pkg::H_GAP;
               cnt_r <= '0;
            end
            fpcp_pkg::H_GAP: if (cnt_r >= 17'(GAP_CYC)) begin
               st_r <= fpcp_pkg::H_LOADW;
            end
            fpcp_pkg::H_LOADW: begin
               if (!st_s_r) begin
                  st_r <= fpcp_pkg::H_WST;
               end else if (WORD_VALID) begin
                  data_r <= WORD & fpcp_pkg::fpcp_mask(SCHEME_SEL);
                  last_r <= WORD_LAST;
                  sub_r <= '0;
                  st_r <= fpcp_pkg::H_SEND;
               end
            end
            fpcp_pkg::H_SEND: begin
               if (rise) begin
                  sub_r <= sub_r + 4'h1;
               end
               if (fall && sub_r == ratio) begin
                  st_r <= last_r ? fpcp_pkg::H_WDONE : fpcp_pkg::H_LOADW;
                  sub_r <= '0;
               end
            end
            fpcp_pkg::H_WDONE: if (dn_s_r) begin
               st_r <= fpcp_pkg::H_FALL;
            end
            fpcp_pkg::H_FALL: if (fall) begin
               sub_r <= sub_r + 4'h1;
               if (sub_r == 4'(`FPCP_END_FALLS - 1)) begin
                  st_r <= fpcp_pkg::H_DONE;
                  cnt_r <= '0;
               end
            end
         endcase
      end
   end
endmodule : fpcp_host
`default_nettype wire

// ### test/fpcp_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fpcp_monitor #(
   parameter int unsigned WORDS = 4,
   parameter int unsigned STAT_MIN = 30
) (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST_B,
   // Link lines.
   input wire logic config_request_n,
   input wire logic config_clock,
   input wire logic [31:0] data,
   input wire logic user_init_clock,
   input wire logic status_n,
   input wire logic load_complete,
   input wire logic init_complete
);
   // ************
   // Helpers
   // ************
   localparam int ST_MAX = 60;
   localparam int END_MAX = 40;
   logic [15:0] low_cnt_r;
   logic [15:0] rise_cnt_r;
   logic [2:0] fall_cnt_r;
   logic req_seen_r;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         low_cnt_r <= 16'h0000;
      end else begin
         low_cnt_r <= status_n ? 16'h0000 : low_cnt_r + 16'h0001;
      end
   end
   // The power-on pulse is not a request pulse, so it skips the length check.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         req_seen_r <= 1'b0;
      end else begin
         req_seen_r <= req_seen_r | !config_request_n;
      end
   end
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rise_cnt_r <= 16'h0000;
      end else if (!config_request_n) begin
         rise_cnt_r <= 16'h0000;
      end else if ($rose(config_clock)) begin
         rise_cnt_r <= rise_cnt_r + 16'h0001;
      end
   end
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fall_cnt_r <= 3'h0;
      end else if (!load_complete) begin
         fall_cnt_r <= 3'h0;
      end else if ($fell(config_clock) && fall_cnt_r != 3'h7) begin
         fall_cnt_r <= fall_cnt_r + 3'h1;
      end
   end
   // ************
   // Properties
   // ************
   req_fall_a: assert property (
      $fell(config_request_n) |-> ##[1:30] (!status_n && !load_complete))
      else $error("flags not low after request");
   req_width_a: assert property (
      $fell(config_request_n) |=> !config_request_n [*8])
      else $error("request pulse too short");
   status_min_a: assert property (
      $rose(status_n) && req_seen_r |-> low_cnt_r >= STAT_MIN)
      else $error("status pulse too short");
   status_max_a: assert property (
      $rose(config_request_n) |-> ##[0:ST_MAX] status_n)
      else $error("status not released in time");
   first_edge_a: assert property (
      $rose(status_n) |-> !config_clock [*8])
      else $error("clock too soon after status");
   all_words_a: assert property (
      $rose(load_complete) |-> rise_cnt_r >= WORDS)
      else $error("load flag before image sent");
   end_falls_a: assert property (
      $rose(load_complete) |-> ##[1:END_MAX] fall_cnt_r == 3'h2)
      else $error("two closing falls missing");
   no_extra_fall_a: assert property (
      fall_cnt_r <= 3'h2)
      else $error("extra clock falls after load");
   data_hold_a: assert property (
      config_clock |-> $stable(data))
      else $error("data changed with clock high");
   init_low_a: assert property (
      $fell(init_complete) |-> load_complete)
      else $error("init flag low before load end");
   cover property ($rose(load_complete));
   cover property ($fell(init_complete));
   cover property ($rose(user_init_clock) && load_complete);
   cover property ($rose(status_n) && req_seen_r);
endmodule : fpcp_monitor
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ************
   // Design and link
   // ************
   localparam int WORDS = 4;
   // rows of scheme, decompress, secure and ratio.
   localparam logic [7:0] ROWS [13] = '{8'h01, 8'h11, 8'h22, 8'h32, 8'h41, 8'h52, 8'h64,
      8'h74, 8'h81, 8'h94, 8'hA8, 8'hB8, 8'hC1};
   logic CLK;
   logic RST_B;
   logic [1:0] sch;
   logic dec, sec, uinit, initp, start, wlast, valid, ready, loaded, user_mode, init_seen, busy;
   logic [31:0] word;
   logic [31:0] last_word;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int rises;
   int urises;
   time t_done;
   fpcp_link_if u_fpcp_link_if ();
   fpcp_device #(.IMAGE_WORDS(WORDS), .POR_CYC(20), .STAT_MIN_CYC(30), .UM_CYC(20),
      .UINIT_PERIODS(10)) u_fpcp_device (.LINK(u_fpcp_link_if.dev), .CLK(CLK), .RST_B(RST_B),
      .SCHEME_SEL(sch), .DECOMP_EN(dec), .SECURE_EN(sec), .UINIT_CLK_EN(uinit),
      .INIT_PIN_EN(initp), .USER_MODE(user_mode), .LAST_WORD(last_word));
   fpcp_host u_fpcp_host (
      .LINK(u_fpcp_link_if.host), .CLK(CLK), .RST_B(RST_B), .SCHEME_SEL(sch), .DECOMP_EN(dec),
      .SECURE_EN(sec), .UINIT_CLK_EN(uinit), .START(start), .WORD(word), .WORD_LAST(wlast),
      .WORD_VALID(valid), .WORD_READY(ready), .BUSY(busy), .LOADED(loaded));
   fpcp_monitor u_fpcp_monitor (.CLK(CLK), .RST_B(RST_B),
      .config_request_n(u_fpcp_link_if.config_request_n),
      .config_clock(u_fpcp_link_if.config_clock), .data(u_fpcp_link_if.data),
      .user_init_clock(u_fpcp_link_if.user_init_clock), .status_n(u_fpcp_link_if.status_n),
      .load_complete(u_fpcp_link_if.load_complete),
      .init_complete(u_fpcp_link_if.init_complete));
   // ************
   // Stimulus
   // ************
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   always @(posedge u_fpcp_link_if.config_clock) if (!u_fpcp_link_if.load_complete) rises++;
   always @(posedge u_fpcp_link_if.user_init_clock) if (u_fpcp_link_if.load_complete) urises++;
   always @(negedge u_fpcp_link_if.init_complete) init_seen = 1'b1;
   always @(posedge u_fpcp_link_if.load_complete) t_done = $time;
   // A hung handshake would otherwise stall the run forever.
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic kick(input logic [3:0] opts);
      @(negedge CLK);
      {sch, dec, sec} = opts;
      rises = 0;
      urises = 0;
      init_seen = 1'b0;
      start = 1'b1;
      @(negedge CLK);
      start = 1'b0;
   endtask : kick
   task automatic load_image(input logic [7:0] row);
      logic [31:0] mask;
      int i;
      int t;
      mask = (row[7:6] == 2'h1) ? 32'h0000FFFF : (row[7:6] == 2'h2) ? 32'hFFFFFFFF : 32'h000000FF;
      kick(row[7:4]);
      for (i = 0; i < WORDS; i++) begin
         word = 32'h89ABCD00 | i;
         wlast = (i == WORDS - 1);
         valid = 1'b1;
         t = 0;
         while (ready !== 1'b1 && t < 2000) begin
            @(negedge CLK);
            t++;
         end
         @(negedge CLK);
      end
      valid = 1'b0;
      t = 0;
      while (user_mode !== 1'b1 && t < 3000) begin
         @(negedge CLK);
         t++;
      end
      chk(rises, WORDS * row[3:0]);
      chk(last_word, (32'h89ABCD00 | (WORDS - 1)) & mask);
      chk({u_fpcp_link_if.status_n, u_fpcp_link_if.load_complete, loaded}, 3'h7);
      chk(u_fpcp_link_if.config_request_n, 1'b1);
      chk(init_seen, initp);
      chk(u_fpcp_link_if.init_complete, 1'b1);
      chk(user_mode, 1'b1);
      chk(busy, 1'b0);
      if (uinit) chk(urises >= 10, 1'b1);
      else chk($time - t_done >= 400, 1'b1);
   endtask : load_image
   initial begin
      RST_B = 1'b0;
      {sch, dec, sec, uinit, initp} = 6'h00;
      {start, wlast, valid} = 3'h0;
      word = 32'h00000000;
      repeat (20) @(negedge CLK);
      RST_B = 1'b1;
      repeat (5) @(negedge CLK);
      chk({u_fpcp_link_if.status_n, u_fpcp_link_if.load_complete, user_mode}, 3'h0);
      repeat (30) @(negedge CLK);
      for (int k = 0; k < 13; k++) begin
         uinit = k[0];
         initp = k[1];
         load_image(ROWS[k]);
      end
      // Reset while the host still holds request low must keep status, load complete and user mode low.
      {uinit, initp} = 2'h0;
      kick(4'hB);
      repeat (60) @(negedge CLK);
      chk(busy, 1'b1);
      RST_B = 1'b0;
      repeat (3) @(negedge CLK);
      chk({u_fpcp_link_if.status_n, u_fpcp_link_if.load_complete, user_mode}, 3'h0);
      RST_B = 1'b1;
      repeat (5) @(negedge CLK);
      chk(u_fpcp_link_if.status_n, 1'b0);
      // A request that lands inside the power-on hold must still be honoured.
      load_image(8'hB8);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
